/* hw/ppio_port_pin_io.sv */
// Purpose: Pin control for four ports: register I/O, logic-array outputs
//          and latched address output, with output enables per pin.
// Assumes: Register window, address/data bus and strobe are synchronous
//          to ref_clk_i; pin levels are asynchronous.
// Notes:   Pin value and enable are registered, one cycle behind causes.
`timescale 1ns/1ps
`include "ppio_regs.svh"

// Operation
// - In register I/O mode an output pin follows its data-out bit.
// - Data-out registers clear to zero on reset.
// - Direction bit 1 makes the pin an output, 0 an input.
// - After reset all pins are high-impedance inputs.
// - Output enable is logic-array enable OR direction bit.
// - An active logic-array enable drives the pin despite direction zero.
// - A logic-output pin ignores data-out; value comes from logic only.
// - A logic-output pin is unavailable to every other pin mode.
// - A logic-input pin stays readable through its data-in bit.
// - Direction still steers the enable of a logic-input pin.
// - Ports A-C reach the logic bus via input macrocells; D directly.
// - Ports A-C take macrocell outputs; port D takes chip selects.
// - A macrocell kept internal leaves its pin free for other uses.
// - Ports A/B address-control bit 1 puts a latched address bit out.
// - Port A gives low address; port B low or high byte per config.
// - Address captured on the latch strobe, held for the bus cycle.
// - Address output is chosen per pin; other pins keep other modes.
// - Port A address control and port D registers clear on reset.
// - Data-in reads 1 for a high pin level, 0 for low.
module ppio_port_pin_io #(
    parameter int SYNC_STAGES = `PPIO_SYNC_STAGES
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [15:0] ad_i,
    input wire logic ale_i,
    input wire logic port_b_addr_high_i,
    input wire logic [7:0] port_a_pins_i,
    input wire logic [7:0] port_b_pins_i,
    input wire logic [7:0] port_c_pins_i,
    input wire logic [7:0] port_d_pins_i,
    output logic [7:0] port_a_pins_o,
    output logic [7:0] port_b_pins_o,
    output logic [7:0] port_c_pins_o,
    output logic [7:0] port_d_pins_o,
    output logic [7:0] port_a_pins_oe_o,
    output logic [7:0] port_b_pins_oe_o,
    output logic [7:0] port_c_pins_oe_o,
    output logic [7:0] port_d_pins_oe_o,
    input wire logic [7:0] port_a_la_out_i,
    input wire logic [7:0] port_b_la_out_i,
    input wire logic [7:0] port_c_la_out_i,
    input wire logic [7:0] port_d_la_out_i,
    input wire logic [7:0] port_a_la_oe_i,
    input wire logic [7:0] port_b_la_oe_i,
    input wire logic [7:0] port_c_la_oe_i,
    input wire logic [7:0] port_d_la_oe_i,
    input wire logic [7:0] port_a_la_sel_i,
    input wire logic [7:0] port_b_la_sel_i,
    input wire logic [7:0] port_c_la_sel_i,
    input wire logic [7:0] port_d_la_sel_i,
    output logic [31:0] la_in_bus_o
);

    if (SYNC_STAGES < 2) begin : g_chk_sync
        $error("ppio_port_pin_io needs at least two sync stages");
    end

    localparam logic [31:0] PIN_MASK = {`PPIO_MASK_D, `PPIO_MASK_C,
                                        `PPIO_MASK_B, `PPIO_MASK_A};

    logic [31:0] pins_in_v;
    logic [31:0] pins_s;
    logic [31:0] la_out_v;
    logic [31:0] la_oe_v;
    logic [31:0] la_sel_v;

    assign pins_in_v = {port_d_pins_i, port_c_pins_i,
                        port_b_pins_i, port_a_pins_i};
    assign la_out_v = {port_d_la_out_i, port_c_la_out_i,
                       port_b_la_out_i, port_a_la_out_i};
    assign la_oe_v = {port_d_la_oe_i, port_c_la_oe_i,
                      port_b_la_oe_i, port_a_la_oe_i};
    // A macrocell kept internal has its select low, so the pin stays free
    assign la_sel_v = {port_d_la_sel_i, port_c_la_sel_i,
                       port_b_la_sel_i, port_a_la_sel_i};

    ppio_pin_sync #(
        .WIDTH(32),
        .STAGES(SYNC_STAGES)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .d_i(pins_in_v),
        .q_o(pins_s)
    );

    // Register file
    logic [31:0] dout_ff;
    logic [31:0] nxt_dout_ff;
    logic [31:0] dir_ff;
    logic [31:0] nxt_dir_ff;
    logic [15:0] actl_ff;
    logic [15:0] nxt_actl_ff;
    ppio_pkg::ppio_byte_type rdata_ff;
    ppio_pkg::ppio_byte_type nxt_rdata_ff;

    always_comb begin
        nxt_dout_ff = dout_ff;
        nxt_dir_ff = dir_ff;
        nxt_actl_ff = actl_ff;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `PPIO_OFS_A_ADDR_OUT_CTRL: nxt_actl_ff[7:0] = reg_wdata_i;
                `PPIO_OFS_B_ADDR_OUT_CTRL: nxt_actl_ff[15:8] = reg_wdata_i;
                `PPIO_OFS_A_DATA_OUT:
                    nxt_dout_ff[7:0] = reg_wdata_i & `PPIO_MASK_A;
                `PPIO_OFS_B_DATA_OUT:
                    nxt_dout_ff[15:8] = reg_wdata_i & `PPIO_MASK_B;
                `PPIO_OFS_C_DATA_OUT:
                    nxt_dout_ff[23:16] = reg_wdata_i & `PPIO_MASK_C;
                `PPIO_OFS_D_DATA_OUT:
                    nxt_dout_ff[31:24] = reg_wdata_i & `PPIO_MASK_D;
                `PPIO_OFS_A_DIRECTION:
                    nxt_dir_ff[7:0] = reg_wdata_i & `PPIO_MASK_A;
                `PPIO_OFS_B_DIRECTION:
                    nxt_dir_ff[15:8] = reg_wdata_i & `PPIO_MASK_B;
                `PPIO_OFS_C_DIRECTION:
                    nxt_dir_ff[23:16] = reg_wdata_i & `PPIO_MASK_C;
                `PPIO_OFS_D_DIRECTION:
                    nxt_dir_ff[31:24] = reg_wdata_i & `PPIO_MASK_D;
                default: begin
                end
            endcase
        end
    end

    // Data-in reads return the synchronised pin level
    always_comb begin
        nxt_rdata_ff = rdata_ff;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `PPIO_OFS_A_DATA_IN: nxt_rdata_ff = pins_s[7:0];
                `PPIO_OFS_B_DATA_IN: nxt_rdata_ff = pins_s[15:8];
                `PPIO_OFS_C_DATA_IN:
                    nxt_rdata_ff = pins_s[23:16] & `PPIO_MASK_C;
                `PPIO_OFS_D_DATA_IN:
                    nxt_rdata_ff = pins_s[31:24] & `PPIO_MASK_D;
                `PPIO_OFS_A_ADDR_OUT_CTRL: nxt_rdata_ff = actl_ff[7:0];
                `PPIO_OFS_B_ADDR_OUT_CTRL: nxt_rdata_ff = actl_ff[15:8];
                `PPIO_OFS_A_DATA_OUT: nxt_rdata_ff = dout_ff[7:0];
                `PPIO_OFS_B_DATA_OUT: nxt_rdata_ff = dout_ff[15:8];
                `PPIO_OFS_C_DATA_OUT: nxt_rdata_ff = dout_ff[23:16];
                `PPIO_OFS_D_DATA_OUT: nxt_rdata_ff = dout_ff[31:24];
                `PPIO_OFS_A_DIRECTION: nxt_rdata_ff = dir_ff[7:0];
                `PPIO_OFS_B_DIRECTION: nxt_rdata_ff = dir_ff[15:8];
                `PPIO_OFS_C_DIRECTION: nxt_rdata_ff = dir_ff[23:16];
                `PPIO_OFS_D_DIRECTION: nxt_rdata_ff = dir_ff[31:24];
                default: nxt_rdata_ff = `PPIO_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            dout_ff <= `PPIO_RST_PINS;
            dir_ff <= `PPIO_RST_PINS;
            actl_ff <= `PPIO_RST_ADDR;
            rdata_ff <= `PPIO_RST_BYTE;
        end else if (ce_i) begin
            dout_ff <= nxt_dout_ff;
            dir_ff <= nxt_dir_ff;
            actl_ff <= nxt_actl_ff;
            rdata_ff <= nxt_rdata_ff;
        end
    end

    // Address latch and logic input bus
    logic [15:0] addr_lat_ff;
    logic [15:0] nxt_addr_lat_ff;
    logic [23:0] imc_ff;
    logic [23:0] nxt_imc_ff;
    logic [31:0] la_in_ff;
    logic [31:0] nxt_la_in_ff;

    always_comb begin
        nxt_addr_lat_ff = ale_i ? ad_i : addr_lat_ff;
        nxt_imc_ff = pins_s[23:0];
        nxt_la_in_ff = {pins_s[31:24], imc_ff};
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            addr_lat_ff <= `PPIO_RST_ADDR;
            imc_ff <= '0;
            la_in_ff <= `PPIO_RST_PINS;
        end else if (ce_i) begin
            addr_lat_ff <= nxt_addr_lat_ff;
            imc_ff <= nxt_imc_ff;
            la_in_ff <= nxt_la_in_ff;
        end
    end

    assign la_in_bus_o = la_in_ff;

    // Pin drivers
    logic [31:0] pin_o_ff;
    logic [31:0] nxt_pin_o_ff;
    logic [31:0] pin_oe_ff;
    logic [31:0] nxt_pin_oe_ff;

    for (genvar i = 0; i < 32; i++) begin : g_pin
        localparam int P = i / 8;
        localparam int B = i % 8;
        logic addr_bit;
        logic actl_bit;
        ppio_pkg::ppio_src_type src;

        if (P == 0) begin : g_port_a
            assign addr_bit = addr_lat_ff[B];
            assign actl_bit = actl_ff[i];
        end else if (P == 1) begin : g_port_b
            assign addr_bit = port_b_addr_high_i ?
                addr_lat_ff[B + `PPIO_ADDR_HI_OFS] : addr_lat_ff[B];
            assign actl_bit = actl_ff[i];
        end else begin : g_port_cd
            assign addr_bit = 1'b0;
            assign actl_bit = 1'b0;
        end

        // Logic-array output wins over every other mode
        always_comb begin
            if (la_sel_v[i]) begin
                src = ppio_pkg::PPIO_SRC_LOGIC;
            end else if (actl_bit) begin
                src = ppio_pkg::PPIO_SRC_ADDR;
            end else begin
                src = ppio_pkg::PPIO_SRC_REG;
            end
        end

        always_comb begin
            case (src)
                ppio_pkg::PPIO_SRC_LOGIC:
                    nxt_pin_o_ff[i] = PIN_MASK[i] & la_out_v[i];
                ppio_pkg::PPIO_SRC_ADDR: nxt_pin_o_ff[i] = addr_bit;
                ppio_pkg::PPIO_SRC_REG: nxt_pin_o_ff[i] = dout_ff[i];
                default: nxt_pin_o_ff[i] = 1'b0;
            endcase
        end

        assign nxt_pin_oe_ff[i] =
            PIN_MASK[i] & (la_oe_v[i] | dir_ff[i]);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pin_o_ff <= `PPIO_RST_PINS;
            pin_oe_ff <= `PPIO_RST_PINS;
        end else if (ce_i) begin
            pin_o_ff <= nxt_pin_o_ff;
            pin_oe_ff <= nxt_pin_oe_ff;
        end
    end

    assign port_a_pins_o = pin_o_ff[7:0];
    assign port_b_pins_o = pin_o_ff[15:8];
    assign port_c_pins_o = pin_o_ff[23:16];
    assign port_d_pins_o = pin_o_ff[31:24];
    assign port_a_pins_oe_o = pin_oe_ff[7:0];
    assign port_b_pins_oe_o = pin_oe_ff[15:8];
    assign port_c_pins_oe_o = pin_oe_ff[23:16];
    assign port_d_pins_oe_o = pin_oe_ff[31:24];
    assign reg_rdata_o = rdata_ff;

    // Checks
    logic [31:0] addr_v;
    logic [31:0] actl_v;
    assign actl_v = {16'h0000, actl_ff};
    assign addr_v = {16'h0000, (port_b_addr_high_i ?
                     addr_lat_ff[15:8] : addr_lat_ff[7:0]),
                     addr_lat_ff[7:0]};

    a_reset_clear: assert property (
        @(posedge ref_clk_i) !resetn_i |=>
            (dout_ff == '0 && dir_ff == '0 && actl_ff == '0 &&
             pin_oe_ff == '0))
        else $error("registers or enables not clear after reset");

    a_oe_or_term: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i |=> pin_oe_ff == ($past(la_oe_v | dir_ff) & PIN_MASK))
        else $error("pin enable is not enable term OR direction");

    a_reg_value: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i |=> ((pin_o_ff ^ $past(dout_ff)) &
                  $past(~la_sel_v & ~actl_v & PIN_MASK)) == '0)
        else $error("register-mode pin does not follow data-out");

    a_logic_value: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i |=> ((pin_o_ff ^ $past(la_out_v)) &
                  $past(la_sel_v & PIN_MASK)) == '0)
        else $error("logic-output pin does not follow logic output");

    a_addr_value: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ce_i |=> ((pin_o_ff ^ $past(addr_v)) &
                  $past(actl_v & ~la_sel_v)) == '0)
        else $error("address pin does not carry latched address");

    a_addr_hold: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && !ale_i) |=> $stable(addr_lat_ff))
        else $error("latched address changed without strobe");

    a_addr_capture: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && ale_i) |=> addr_lat_ff == $past(ad_i))
        else $error("address not captured on strobe");

    a_unused_bits: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ((dout_ff | dir_ff | pin_oe_ff | pin_o_ff) & ~PIN_MASK) == '0)
        else $error("bit without a pin became active");

    a_din_read: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && reg_rd_i && reg_addr_i == `PPIO_OFS_A_DATA_IN) |=>
            reg_rdata_o == $past(pins_s[7:0]))
        else $error("data-in read does not show pin level");

    a_dir_write: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && reg_wr_i && reg_addr_i == `PPIO_OFS_B_DIRECTION) |=>
            (dir_ff[15:8] == $past(reg_wdata_i)) ##1
            (!$past(ce_i) ||
             (port_b_pins_oe_o & $past(dir_ff[15:8])) ==
             $past(dir_ff[15:8])))
        else $error("direction write did not take effect");

    c_addr_out: cover property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ale_i ##1 (actl_ff[0] && pin_oe_ff[0]));
    c_logic_out: cover property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        la_sel_v[8] && la_oe_v[8] ##1 pin_oe_ff[8]);
    c_oe_from_term: cover property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (la_oe_v[24] && !dir_ff[24]) ##1 pin_oe_ff[24]);
    c_din_read: cover property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == `PPIO_OFS_C_DATA_IN);

endmodule : ppio_port_pin_io

/* hw/ppio_regs.svh */
// Purpose: Register offsets, reset values, pin masks and address
//          positions of the port pin block.
// Assumes: Processor register window with 8-bit offsets and data.
// Notes:   Definitions only.
`ifndef PPIO_REGS_SVH
`define PPIO_REGS_SVH

`define PPIO_OFS_A_DATA_IN 8'h00
`define PPIO_OFS_B_DATA_IN 8'h01
`define PPIO_OFS_A_ADDR_OUT_CTRL 8'h02
`define PPIO_OFS_B_ADDR_OUT_CTRL 8'h03
`define PPIO_OFS_A_DATA_OUT 8'h04
`define PPIO_OFS_B_DATA_OUT 8'h05
`define PPIO_OFS_A_DIRECTION 8'h06
`define PPIO_OFS_B_DIRECTION 8'h07
`define PPIO_OFS_C_DATA_IN 8'h10
`define PPIO_OFS_D_DATA_IN 8'h11
`define PPIO_OFS_C_DATA_OUT 8'h12
`define PPIO_OFS_D_DATA_OUT 8'h13
`define PPIO_OFS_C_DIRECTION 8'h14
`define PPIO_OFS_D_DIRECTION 8'h15

`define PPIO_RST_BYTE 8'h00
`define PPIO_RST_ADDR 16'h0000
`define PPIO_RST_PINS 32'h0000_0000

// Bits that have a pin behind them
`define PPIO_MASK_A 8'hff
`define PPIO_MASK_B 8'hff
`define PPIO_MASK_C 8'h9c
`define PPIO_MASK_D 8'h06

// Port B pin n carries address bit n, or n plus this when high byte chosen
`define PPIO_ADDR_HI_OFS 8

`define PPIO_SYNC_STAGES 2

`endif

/* hw/ppio_pkg.sv */
// Purpose: Types shared by the port pin block.
// Assumes: Nothing beyond the register header.
// Notes:   Constants live in ppio_regs.svh.
package ppio_pkg;

    typedef logic [7:0] ppio_byte_type;

    // Which source drives a pin's output value
    typedef enum logic [1:0] {
        PPIO_SRC_REG,
        PPIO_SRC_ADDR,
        PPIO_SRC_LOGIC
    } ppio_src_type;

endpackage : ppio_pkg

/* hw/ppio_pin_sync.sv */
// Purpose: Multi-stage synchroniser for asynchronous pin levels.
// Assumes: Inputs are levels from outside the clock domain.
// Notes:   Only the last stage may be read by other logic.
`timescale 1ns/1ps
`include "ppio_regs.svh"

module ppio_pin_sync #(
    parameter int WIDTH = 32,
    parameter int STAGES = `PPIO_SYNC_STAGES
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    if (STAGES < 2) begin : g_chk_stages
        $error("ppio_pin_sync needs at least two stages");
    end
    if (WIDTH < 1) begin : g_chk_width
        $error("ppio_pin_sync needs a width of at least one");
    end

    logic [WIDTH-1:0] chain_ff [STAGES];
    logic [WIDTH-1:0] nxt_chain_ff [STAGES];

    always_comb begin
        nxt_chain_ff[0] = d_i;
        for (int s = 1; s < STAGES; s++) begin
            nxt_chain_ff[s] = chain_ff[s-1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            for (int s = 0; s < STAGES; s++) begin
                chain_ff[s] <= '0;
            end
        end else if (ce_i) begin
            for (int s = 0; s < STAGES; s++) begin
                chain_ff[s] <= nxt_chain_ff[s];
            end
        end
    end

    assign q_o = chain_ff[STAGES-1];

endmodule : ppio_pin_sync

/* dv/ppio_pin_model.sv */
// Purpose: External peripheral side of the port pins, wire resolution.
// Assumes: 32 pins {D,C,B,A}; weak pull-ups on every pin.
// Notes:   Undriven pins read high through the pull-up.
`timescale 1ns/1ps

module ppio_pin_model (
    input wire logic [31:0] pins_i,
    input wire logic [31:0] oe_i,
    input wire logic [31:0] ext_val_i,
    input wire logic [31:0] ext_en_i,
    output logic [31:0] level_o
);
    // Each pin is driven by the device or the peripheral, else pulled up
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (oe_i[i]) begin
                level_o[i] = pins_i[i];
            end else if (ext_en_i[i]) begin
                level_o[i] = ext_val_i[i];
            end else begin
                level_o[i] = 1'b1;
            end
        end
    end
endmodule : ppio_pin_model

/* dv/tb_port_pin_io_and_address_out.sv */
// Purpose: Self-checking bench of the port pin block.
// Assumes: One-cycle strobes; read data shows one edge after the read.
// Notes:   Clock enable dropped once to check that state freezes.
`timescale 1ns/1ps

module tb_port_pin_io_and_address_out;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [15:0] ad = 16'h0000;
    logic ale = 1'b0;
    logic bhi = 1'b0;
    logic ce = 1'b1;
    wire logic [31:0] pin_o, pin_oe;
    logic [31:0] lvl, la_in;
    logic [31:0] ext_val = '0, ext_en = '0;
    logic [31:0] la_out = '0, la_oe = '0, la_sel = '0;
    logic [7:0] ofs [10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                             8'h12, 8'h13, 8'h14, 8'h15};
    int err_count = 0;
    int compares = 0;
    int cyc = 0;

    ppio_port_pin_io u_dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .ad_i(ad), .ale_i(ale), .port_b_addr_high_i(bhi),
        .port_a_pins_i(lvl[7:0]), .port_b_pins_i(lvl[15:8]),
        .port_c_pins_i(lvl[23:16]), .port_d_pins_i(lvl[31:24]),
        .port_a_pins_o(pin_o[7:0]), .port_b_pins_o(pin_o[15:8]),
        .port_c_pins_o(pin_o[23:16]), .port_d_pins_o(pin_o[31:24]),
        .port_a_pins_oe_o(pin_oe[7:0]), .port_b_pins_oe_o(pin_oe[15:8]),
        .port_c_pins_oe_o(pin_oe[23:16]), .port_d_pins_oe_o(pin_oe[31:24]),
        .port_a_la_out_i(la_out[7:0]), .port_b_la_out_i(la_out[15:8]),
        .port_c_la_out_i(la_out[23:16]), .port_d_la_out_i(la_out[31:24]),
        .port_a_la_oe_i(la_oe[7:0]), .port_b_la_oe_i(la_oe[15:8]),
        .port_c_la_oe_i(la_oe[23:16]), .port_d_la_oe_i(la_oe[31:24]),
        .port_a_la_sel_i(la_sel[7:0]), .port_b_la_sel_i(la_sel[15:8]),
        .port_c_la_sel_i(la_sel[23:16]), .port_d_la_sel_i(la_sel[31:24]),
        .la_in_bus_o(la_in)
    );

    ppio_pin_model u_ext (
        .pins_i(pin_o), .oe_i(pin_oe), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .level_o(lvl)
    );

    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask : wr8

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1;
        chk({24'h0, rdata}, {24'h0, exp});
    endtask : rd_chk

    task automatic settle;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask : settle

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        repeat (4) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        chk(pin_oe, 32'h0);
        for (int i = 0; i < 10; i++) begin
            rd_chk(ofs[i], 8'h00);
        end
        settle();
        rd_chk(8'h00, 8'hff);
        // Output values and mixed directions
        wr8(8'h06, 8'hff);
        wr8(8'h04, 8'ha5);
        wr8(8'h07, 8'h0f);
        wr8(8'h05, 8'h3c);
        @(posedge ref_clk_i);
        ext_en <= 32'h0000_f000;
        ext_val <= 32'h0000_9000;
        settle();
        chk(pin_oe[15:0], 32'h0fff);
        chk(pin_o[11:0], 32'h0ca5);
        rd_chk(8'h04, 8'ha5);
        rd_chk(8'h01, 8'h9c);
        // Output enable from logic-array term
        wr8(8'h06, 8'h00);
        @(posedge ref_clk_i);
        la_oe <= 32'h0000_00f0;
        settle();
        chk(pin_oe[7:0], 32'hf0);
        wr8(8'h06, 8'h03);
        settle();
        chk(pin_oe[7:0], 32'hf3);
        // Logic-array outputs override address and data-out
        @(posedge ref_clk_i);
        la_out <= 32'h0000_005a;
        la_sel <= 32'h0000_000f;
        wr8(8'h02, 8'hff);
        @(posedge ref_clk_i);
        ad <= 16'h1234;
        ale <= 1'b1;
        @(posedge ref_clk_i);
        ale <= 1'b0;
        ad <= 16'hbeef;
        settle();
        chk(pin_o[7:0], 32'h3a);
        wr8(8'h02, 8'h00);
        settle();
        chk(pin_o[7:0], 32'haa);
        // Port B address byte selection on part of the port
        @(posedge ref_clk_i);
        bhi <= 1'b1;
        wr8(8'h03, 8'h0f);
        settle();
        chk(pin_o[15:8], 32'h32);
        @(posedge ref_clk_i);
        bhi <= 1'b0;
        settle();
        chk(pin_o[15:8], 32'h34);
        // Bits without pins on ports C and D
        wr8(8'h12, 8'hff);
        wr8(8'h14, 8'hff);
        wr8(8'h13, 8'hff);
        wr8(8'h15, 8'hff);
        rd_chk(8'h12, 8'h9c);
        rd_chk(8'h14, 8'h9c);
        rd_chk(8'h13, 8'h06);
        rd_chk(8'h15, 8'h06);
        settle();
        chk(pin_oe[31:16], 32'h069c);
        chk(pin_o[31:16], 32'h069c);
        @(posedge ref_clk_i);
        la_sel <= 32'h0604_000f;
        la_out <= 32'h0200_005a;
        settle();
        chk(pin_o[31:16], 32'h0298);
        wr8(8'h20, 8'hff);
        rd_chk(8'h20, 8'h00);
        // A write while the clock enable is low must not land
        @(posedge ref_clk_i);
        ce <= 1'b0;
        wr8(8'h04, 8'h00);
        @(posedge ref_clk_i);
        ce <= 1'b1;
        rd_chk(8'h04, 8'ha5);
        // Port D reaches the logic bus one edge before port C
        wr8(8'h14, 8'h00);
        wr8(8'h15, 8'h00);
        @(posedge ref_clk_i);
        ext_en <= 32'hffff_f000;
        ext_val <= 32'h0000_9000;
        settle();
        settle();
        @(posedge ref_clk_i);
        ext_val <= 32'hffff_9000;
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (la_in[25] === 1'b1) begin
                break;
            end
        end
        chk({la_in[25], la_in[18]}, 32'h2);
        @(posedge ref_clk_i);
        #1;
        chk({la_in[25], la_in[18]}, 32'h3);
        conclude();
    end
endmodule : tb_port_pin_io_and_address_out
